// file: logic/cmc_map.svh
// Register map, field positions and timing counts of the clock multiplier control.
// Assumes inclusion by the package and the modules of this block only.
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

// ****************************************
// Special-function register location
// ****************************************
`define CMC_SFR_ADDR       8'h97
`define CMC_SFR_PAGE       8'h0f
`define CMC_RESET_VALUE    8'h00

// ****************************************
// Field positions
// ****************************************
`define CMC_BIT_ENABLE     7
`define CMC_BIT_INIT       6
`define CMC_BIT_READY      5
`define CMC_SCALE_HI       4
`define CMC_SCALE_LO       2
`define CMC_SEL_HI         1
`define CMC_SEL_LO         0

// ****************************************
// Timing
// ****************************************
`define CMC_CLK_MHZ        25
`define CMC_LOCK_TIME_US   20
`define CMC_LOCK_CYCLES    (`CMC_LOCK_TIME_US * `CMC_CLK_MHZ)
`define CMC_OSC_DIV_W      6

`endif

// file: logic/cmc_pkg.sv
// Types shared by the clock multiplier control modules.
// Assumes cmc_map.svh sits on the include path.
package cmc_pkg;
`include "cmc_map.svh"

   // Input select encodings
   typedef enum logic [1:0] {
      CMC_SEL_INT_X2 = 2'h0,
      CMC_SEL_EXT_X2 = 2'h1,
      CMC_SEL_INT_X4 = 2'h2,
      CMC_SEL_EXT_X4 = 2'h3
   } cmc_sel_t;

   // External oscillator drive modes seen by the pin logic
   typedef enum logic [1:0] {
      CMC_XOSC_OFF  = 2'h0,
      CMC_XOSC_XTAL = 2'h1,
      CMC_XOSC_RC   = 2'h2,
      CMC_XOSC_CMOS = 2'h3
   } cmc_xosc_t;

   // Lock sequencer states, one-hot
   typedef enum logic [2:0] {
      CMC_ST_OFF  = 3'h1,
      CMC_ST_LOCK = 3'h2,
      CMC_ST_RDY  = 3'h4
   } cmc_state_t;
endpackage

// file: logic/cmc_scale_if.sv
// Carrier between the control core and the output scaler.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface cmc_scale_if;
   logic       run;      // Multiplier locked and enabled
   logic       times4;   // Times-four base selected
   logic [2:0] scale;    // Scaling field
   logic       clk_en;   // Output pulse enable

   modport ctrl (output run, output times4, output scale, input clk_en);
   modport scaler (input run, input times4, input scale, output clk_en);
endinterface : cmc_scale_if

// file: logic/cmc_scaler.sv
// Output scaler: turns the base pulse train into the scaled output enable.
// Assumes base pulses arrive every clock; 2/N emits 2 pulses per N clocks.
`timescale 1ns/1ps
module cmc_scaler
   import cmc_pkg::*;
(
   // Clock and reset
   input wire logic  clk,
   input wire logic  rst_n,
   // Control side
   cmc_scale_if.scaler sif
);

   logic [2:0] cnt_q, cnt_d;
   logic       en_q, en_d;
   logic [2:0] period;

   // ****************************************
   // Period per scaling code
   // ****************************************
   always_comb begin
      case (sif.scale)
         3'h1:    period = 3'h3;   // 2/3
         3'h2:    period = 3'h4;   // 2/4
         3'h3:    period = 3'h5;   // 2/5
         3'h4:    period = 3'h6;   // 2/6
         3'h5:    period = 3'h7;   // 2/7
         default: period = 3'h1;   // Factor of one
      endcase
   end

   // Two pulses back to back per period: duty is uneven for odd N
   always_comb begin
      cnt_d = cnt_q;
      en_d  = 1'b0;
      if (!sif.run) begin
         cnt_d = 3'h0;
      end else if (!sif.times4 || period == 3'h1) begin
         en_d  = 1'b1;
         cnt_d = 3'h0;
      end else begin
         en_d  = (cnt_q < 3'h2);
         cnt_d = (cnt_q >= period - 3'h1) ? 3'h0 : cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 3'h0;
         en_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         en_q  <= en_d;
      end
   end

   assign sif.clk_en = en_q;

endmodule // cmc_scaler

// file: logic/cmc_top.sv
// Clock multiplier control: special-function register, lock sequencer,
// output gating and oscillator pin takeover.
// Assumes a byte-wide SFR bus with one-cycle read/write strobes on CORE_CLK.
//
// Summary of operation
// - Register: enable bit7, init bit6, ready bit5 read-only, scale 4:2, select 1:0.
// - Register decoded at address 0x97 only when SFR page is 0x0f.
// - Writing init one while enabled starts lock; disabled keeps multiplier off.
// - Ready reads one only after lock achieved, zero otherwise.
// - Select 00 int x2, 01 ext x2, 10 int x4, 11 ext x4.
// - Scale 000 gives the unscaled base output.
// - Either times-two selection ignores the scale field.
// - Some non-unity scalings give uneven duty cycle.
// - Crystal mode takes pins P0.2 and P0.3 as oscillator terminals.
// - RC or CMOS mode uses only P0.3 as input terminal.
// - Scale field selects factors 1, 2/3, 2/4, 2/5, 2/6, 2/7.
`timescale 1ns/1ps
module cmc_top
   import cmc_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = `CMC_LOCK_CYCLES
)(
   // Clock and reset
   input  wire logic       CORE_CLK,
   input  wire logic       RST_N,
   // SFR bus
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic [7:0] SFR_PAGE,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   input  wire logic [7:0] SFR_WDATA,
   output logic      [7:0] SFR_RDATA,
   output logic            SFR_HIT,
   // External oscillator mode from its own control register
   input  wire cmc_xosc_t  XOSC_MODE,
   // Pin takeover towards the port logic
   output logic            P02_OSC_TAKE,
   output logic            P03_OSC_TAKE,
   // Multiplier output
   output logic            MUL_CLK_EN,
   output logic            MUL_ACTIVE,
   output logic            MUL_TIMES4,
   output logic            MUL_EXT_SRC
);

   // ****************************************
   // Local declarations
   // ****************************************
   localparam int LCW = $clog2(LOCK_CYCLES + 1);

   logic             en_q, en_d;
   logic [2:0]       scale_q, scale_d;
   cmc_sel_t         sel_q, sel_d;
   cmc_state_t       st_q, st_d;
   logic [LCW-1:0]   lcnt_q, lcnt_d;
   logic [7:0]       rdata_q, rdata_d;
   logic             take2_q, take2_d;
   logic             take3_q, take3_d;
   logic             wr_hit, rd_hit, ready;

   cmc_scale_if sif ();

   // Address plus page match, shared by read and write
   function automatic logic sfr_match(input logic [7:0] a, input logic [7:0] p);
      return (a == `CMC_SFR_ADDR) && (p == `CMC_SFR_PAGE);
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   always_comb begin
      wr_hit = 1'b0;
      rd_hit = 1'b0;
      if (sfr_match(SFR_ADDR, SFR_PAGE)) begin
         wr_hit = SFR_WR;
         rd_hit = SFR_RD;
      end
   end

   assign SFR_HIT = sfr_match(SFR_ADDR, SFR_PAGE);
   assign ready   = (st_q == CMC_ST_RDY);

   // ****************************************
   // Register fields
   // ****************************************
   // Init is a trigger, not stored: a read always shows it as zero
   always_comb begin
      en_d    = en_q;
      scale_d = scale_q;
      sel_d   = sel_q;
      if (wr_hit) begin
         en_d    = SFR_WDATA[`CMC_BIT_ENABLE];
         scale_d = SFR_WDATA[`CMC_SCALE_HI:`CMC_SCALE_LO];
         sel_d   = cmc_sel_t'(SFR_WDATA[`CMC_SEL_HI:`CMC_SEL_LO]);
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en_q    <= 1'b0;
         scale_q <= 3'h0;
         sel_q   <= CMC_SEL_INT_X2;
      end else begin
         en_q    <= en_d;
         scale_q <= scale_d;
         sel_q   <= sel_d;
      end
   end

   // ****************************************
   // Lock sequencer
   // ****************************************
   // Lock is modelled as a fixed settle count; the real loop may differ
   always_comb begin
      st_d   = st_q;
      lcnt_d = lcnt_q;
      case (st_q)
         CMC_ST_OFF: begin
            lcnt_d = '0;
            if (wr_hit && en_q && SFR_WDATA[`CMC_BIT_ENABLE] && SFR_WDATA[`CMC_BIT_INIT]) begin
               st_d = CMC_ST_LOCK;
            end
         end
         CMC_ST_LOCK: begin
            if (lcnt_q == LCW'(LOCK_CYCLES - 1)) begin
               st_d = CMC_ST_RDY;
            end else begin
               lcnt_d = lcnt_q + 1'b1;
            end
         end
         CMC_ST_RDY: begin
            lcnt_d = '0;
         end
         default: begin
            st_d   = CMC_ST_OFF;
            lcnt_d = '0;
         end
      endcase
      // Dropping enable wins over everything, also the all-zero write
      if (!en_d) begin
         st_d   = CMC_ST_OFF;
         lcnt_d = '0;
      end else if (wr_hit && SFR_WDATA[`CMC_BIT_INIT] && st_q != CMC_ST_OFF) begin
         st_d   = CMC_ST_LOCK;
         lcnt_d = '0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q   <= CMC_ST_OFF;
         lcnt_q <= '0;
      end else begin
         st_q   <= st_d;
         lcnt_q <= lcnt_d;
      end
   end

   // ****************************************
   // Read data and pin takeover
   // ****************************************
   always_comb begin
      rdata_d = 8'h00;
      if (rd_hit) begin
         rdata_d[`CMC_BIT_ENABLE]              = en_q;
         rdata_d[`CMC_BIT_READY]               = ready;
         rdata_d[`CMC_SCALE_HI:`CMC_SCALE_LO]  = scale_q;
         rdata_d[`CMC_SEL_HI:`CMC_SEL_LO]      = sel_q;
      end
      take2_d = (XOSC_MODE == CMC_XOSC_XTAL);
      take3_d = (XOSC_MODE != CMC_XOSC_OFF);
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_q <= 8'h00;
         take2_q <= 1'b0;
         take3_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         take2_q <= take2_d;
         take3_q <= take3_d;
      end
   end

   // ****************************************
   // Output scaling
   // ****************************************
   assign sif.run    = en_q && ready;
   assign sif.times4 = sel_q[1];
   assign sif.scale  = scale_q;

   cmc_scaler u_scaler (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .sif   (sif.scaler)
   );

   // Ports
   assign SFR_RDATA    = rdata_q;
   assign P02_OSC_TAKE = take2_q;
   assign P03_OSC_TAKE = take3_q;
   assign MUL_CLK_EN   = sif.clk_en;
   assign MUL_ACTIVE   = sif.run;
   assign MUL_TIMES4   = sel_q[1];
   assign MUL_EXT_SRC  = sel_q[0];

endmodule // cmc_top

// file: tb/cmc_chk.sv
// Port assertions for the clock multiplier control.
// Assumes binding onto cmc_top and a single clock domain.
`timescale 1ns/1ps
module cmc_chk
   import cmc_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = 4
)(
   // Clock and reset
   input wire logic       CORE_CLK,
   input wire logic       RST_N,
   // Register bus
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_PAGE,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       SFR_HIT,
   // Oscillator and outputs
   input wire cmc_xosc_t  XOSC_MODE,
   input wire logic       P02_OSC_TAKE,
   input wire logic       P03_OSC_TAKE,
   input wire logic       MUL_CLK_EN,
   input wire logic       MUL_ACTIVE,
   input wire logic       MUL_TIMES4,
   input wire logic       MUL_EXT_SRC
);
   localparam int LOCK_MAX = LOCK_CYCLES + 3;
   logic        en_q, en_d;
   logic [15:0] cnt_q, cnt_d;

   // ****************************************
   // Helper state
   // ****************************************
   // Enable mirror and cycles since last init write; saturates to stay safe
   always_comb begin
      en_d  = en_q;
      cnt_d = (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h1;
      if (SFR_WR && SFR_HIT) en_d = SFR_WDATA[7];
      if (SFR_WR && SFR_HIT && SFR_WDATA[6]) cnt_d = 16'h0;
   end
   // Register the helper state
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en_q  <= 1'b0;
         cnt_q <= 16'h0;
      end else begin
         en_q  <= en_d;
         cnt_q <= cnt_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   a_hit_decode: assert property (SFR_HIT == (SFR_ADDR == 8'h97 && SFR_PAGE == 8'h0f))
      else $error("hit flag disagrees with address decode");
   a_idle_rdata: assert property (!$past(SFR_RD && SFR_HIT) |-> SFR_RDATA == 8'h00)
      else $error("read data not zero without a hit read");
   a_read_fields: assert property ($past(SFR_RD && SFR_HIT) |-> !SFR_RDATA[6]
      && SFR_RDATA[5] == $past(MUL_ACTIVE) && SFR_RDATA[1:0] == {$past(MUL_TIMES4), $past(MUL_EXT_SRC)})
      else $error("read data fields disagree with outputs");
   a_lock_bound: assert property (SFR_WR && SFR_HIT && SFR_WDATA[7:6] == 2'b11 && en_q
      |-> ##[1:LOCK_MAX] MUL_ACTIVE) else $error("lock not reached in time");
   a_ready_early: assert property ($rose(MUL_ACTIVE) |-> cnt_q >= LOCK_CYCLES)
      else $error("ready rose before lock time");
   a_disable_off: assert property (SFR_WR && SFR_HIT && !SFR_WDATA[7] |=> !MUL_ACTIVE ##1 !MUL_CLK_EN)
      else $error("disable write did not stop output");
   a_gate_idle: assert property (!$past(MUL_ACTIVE) |-> !MUL_CLK_EN)
      else $error("output pulse while not active");
   a_x2_unscaled: assert property ($past(MUL_ACTIVE, 2) && $past(MUL_ACTIVE) && !$past(MUL_TIMES4, 2)
      && !$past(MUL_TIMES4) |-> MUL_CLK_EN) else $error("times-two output missed a pulse");
   // Takeover flops start from zero after reset, whatever mode stood during it
   a_pin_take: assert property ($past(RST_N) |-> P02_OSC_TAKE == ($past(XOSC_MODE) == CMC_XOSC_XTAL)
      && P03_OSC_TAKE == ($past(XOSC_MODE) != CMC_XOSC_OFF)) else $error("pin takeover wrong for mode");

   // Main scenarios reached
   c_lock: cover property ($rose(MUL_ACTIVE));
   c_pin2: cover property (P02_OSC_TAKE);
   c_read: cover property (SFR_RD && SFR_HIT && en_q);
endmodule // cmc_chk

bind cmc_top cmc_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .SFR_ADDR(SFR_ADDR), .SFR_PAGE(SFR_PAGE), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
   .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .XOSC_MODE(XOSC_MODE), .P02_OSC_TAKE(P02_OSC_TAKE),
   .P03_OSC_TAKE(P03_OSC_TAKE), .MUL_CLK_EN(MUL_CLK_EN), .MUL_ACTIVE(MUL_ACTIVE),
   .MUL_TIMES4(MUL_TIMES4), .MUL_EXT_SRC(MUL_EXT_SRC));

// file: tb/cmc_top_tb_top.sv
// Self-checking bench for the clock multiplier control.
// Assumes cmc_top with a short lock count and the bound checker.
`timescale 1ns/1ps
module cmc_top_tb_top
   import cmc_pkg::*;
;
   localparam int unsigned LOCK = 4;
   logic       CORE_CLK, RST_N, SFR_WR, SFR_RD, SFR_HIT;
   logic [7:0] SFR_ADDR, SFR_PAGE, SFR_WDATA, SFR_RDATA;
   logic       P02_OSC_TAKE, P03_OSC_TAKE, MUL_CLK_EN, MUL_ACTIVE, MUL_TIMES4, MUL_EXT_SRC;
   cmc_xosc_t  XOSC_MODE;
   int         bad_count = 0;
   int         tests_run = 0;
   int         n;
   // Rows: write data in the high byte, expected readback in the low byte
   logic [15:0] rows [8] = '{16'h0000, 16'h1f1f, 16'h0d0d, 16'h1212, 16'h5e1e, 16'h2000, 16'h8383, 16'h9f9f};
   logic [1:0]  pins [4] = '{2'h0, 2'h3, 2'h1, 2'h1};

   cmc_top #(.LOCK_CYCLES(LOCK)) dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
      .SFR_PAGE(SFR_PAGE), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
      .SFR_HIT(SFR_HIT), .XOSC_MODE(XOSC_MODE), .P02_OSC_TAKE(P02_OSC_TAKE), .P03_OSC_TAKE(P03_OSC_TAKE),
      .MUL_CLK_EN(MUL_CLK_EN), .MUL_ACTIVE(MUL_ACTIVE), .MUL_TIMES4(MUL_TIMES4), .MUL_EXT_SRC(MUL_EXT_SRC));

   // ****************************************
   // Tasks
   // ****************************************
   // Compare and count
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle write strobe
   task wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
      @(posedge CORE_CLK); #1;
      SFR_ADDR = a; SFR_PAGE = p; SFR_WDATA = d; SFR_WR = 1'b1;
      @(posedge CORE_CLK); #1;
      SFR_WR = 1'b0;
   endtask
   // One-cycle read strobe; data is registered, so look after the next edge
   task rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
      @(posedge CORE_CLK); #1;
      SFR_ADDR = a; SFR_PAGE = p; SFR_RD = 1'b1;
      @(posedge CORE_CLK); #1;
      SFR_RD = 1'b0;
      chk(SFR_RDATA, e);
   endtask
   // Count output pulses over 42 cycles, a multiple of scaling periods 1, 3, 6 and 7 but not 4 or 5
   task pulses(input logic [7:0] d, input logic [7:0] e);
      int p;
      p = 0;
      wr(8'h97, 8'h0f, d);
      repeat (3) @(posedge CORE_CLK);
      repeat (42) begin
         @(posedge CORE_CLK); #1;
         p += int'(MUL_CLK_EN);
      end
      chk(8'(p), e);
   endtask
   // Single end point of the run
   task conclude();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************
   // Clock and watchdog
   // ****************************************
   initial begin
      CORE_CLK = 1'b0;
      forever #20 CORE_CLK = ~CORE_CLK;
   end
   // Whole run is a few hundred cycles; 10000 means a hang
   initial begin
      #400000;
      bad_count++;
      conclude();
   end

   // ****************************************
   // Stimulus
   // ****************************************
   initial begin
      RST_N = 1'b0; SFR_ADDR = 8'h0; SFR_PAGE = 8'h0; SFR_WR = 1'b0; SFR_RD = 1'b0; SFR_WDATA = 8'h0;
      XOSC_MODE = CMC_XOSC_OFF;
      repeat (5) @(posedge CORE_CLK);
      chk({MUL_ACTIVE, MUL_CLK_EN, P03_OSC_TAKE, SFR_RDATA[4:0]}, 8'h00);
      chk({2'h0, SFR_RDATA[7:5], P02_OSC_TAKE, MUL_TIMES4, MUL_EXT_SRC}, 8'h00);
      #1 RST_N = 1'b1;
      rd(8'h97, 8'h0f, 8'h00);
      chk(8'(SFR_HIT), 8'h01);
      // Field table: write then read back
      for (int i = 0; i < 8; i++) begin
         wr(8'h97, 8'h0f, rows[i][15:8]);
         chk(8'({MUL_TIMES4, MUL_EXT_SRC}), 8'(rows[i][1:0]));
         rd(8'h97, 8'h0f, rows[i][7:0]);
      end
      // Oscillator modes and pin takeover
      for (int m = 0; m < 4; m++) begin
         XOSC_MODE = cmc_xosc_t'(m);
         repeat (2) @(posedge CORE_CLK); #1;
         chk(8'({P02_OSC_TAKE, P03_OSC_TAKE}), 8'(pins[m]));
      end
      // Wrong page or address is neither written nor read
      wr(8'h97, 8'h0f, 8'h00);
      wr(8'h97, 8'h0e, 8'h9f);
      wr(8'h96, 8'h0f, 8'h9f);
      rd(8'h97, 8'h0f, 8'h00);
      rd(8'h96, 8'h0f, 8'h00);
      chk(8'(SFR_HIT), 8'h00);
      // Bring-up in software order after the clearing write: select, scale, enable, settle, init
      wr(8'h97, 8'h0f, 8'h02);
      wr(8'h97, 8'h0f, 8'h0a);
      wr(8'h97, 8'h0f, 8'h8a);
      // 130 cycles of 40 ns exceed the settle time before init
      repeat (130) @(posedge CORE_CLK);
      wr(8'h97, 8'h0f, 8'hca);
      rd(8'h97, 8'h0f, 8'h8a);
      n = 0;
      while (!MUL_ACTIVE && n < 50) begin
         @(posedge CORE_CLK); #1;
         n++;
      end
      chk(8'(n < 50), 8'h01);
      rd(8'h97, 8'h0f, 8'haa);
      // Init again while ready restarts the full lock count
      wr(8'h97, 8'h0f, 8'hca);
      chk(8'(MUL_ACTIVE), 8'h00);
      repeat (LOCK - 1) @(posedge CORE_CLK); #1;
      chk(8'(MUL_ACTIVE), 8'h00);
      @(posedge CORE_CLK); #1;
      chk(8'(MUL_ACTIVE), 8'h01);
      // Scaled outputs: 2/3, 2/7, times two ignoring scale, unity
      pulses(8'h86, 8'd28);
      pulses(8'h96, 8'd12);
      pulses(8'h94, 8'd42);
      pulses(8'h82, 8'd42);
      // All-zero write drops ready and the output
      wr(8'h97, 8'h0f, 8'h00);
      chk(8'(MUL_ACTIVE), 8'h00);
      @(posedge CORE_CLK); #1;
      chk(8'(MUL_CLK_EN), 8'h00);
      rd(8'h97, 8'h0f, 8'h00);
      // Initialise while the register is still disabled is ignored
      wr(8'h97, 8'h0f, 8'hc0);
      repeat (LOCK + 6) @(posedge CORE_CLK); #1;
      chk(8'(MUL_ACTIVE), 8'h00);
      rd(8'h97, 8'h0f, 8'h80);
      // Second reset in mid-run
      RST_N = 1'b0;
      repeat (2) @(posedge CORE_CLK); #1;
      RST_N = 1'b1;
      rd(8'h97, 8'h0f, 8'h00);
      conclude();
   end
endmodule // cmc_top_tb_top
